// ---- verilog/rps_regs.svh ----
// Constants of the ring path selector: field codes, encodings, widths.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

// Width of a destination MAC address
`define RPS_ADDR_W 48
// Group bit of a destination address; set means multicast
`define RPS_GROUP_BIT 40
// Codes of the client's requested ring path
`define RPS_REQ_PATH_ZERO 2'h0
`define RPS_REQ_PATH_ONE 2'h1
`define RPS_REQ_PATH_DEFAULT 2'h2
`define RPS_REQ_PATH_NONE 2'h3
// Header path field values
`define RPS_HDR_PATH_ZERO 1'h0
`define RPS_HDR_PATH_ONE 1'h1
// Protection choice values
`define RPS_NO_PROTECT 1'h0
`define RPS_PROTECT 1'h1
// Wrap-eligibility mark values
`define RPS_STEER_ONLY_MARK 1'h0
`define RPS_LOOPBACK_OK_MARK 1'h1
// Width of the event counters
`define RPS_CNT_W 16
// Reset values
`define RPS_RST_CNT 16'h0000
`define RPS_RST_ADDR 48'h000000000000

`endif

// ---- verilog/rps_pkg.sv ----
// Types of the ring path selector.
// Assumes nothing of its surroundings.
package rps_pkg;

  typedef enum logic [3:0] {
    RPS_START = 4'h0,
    RPS_PATH_ZERO_STATE = 4'h1,
    RPS_PATH_ONE_STATE = 4'h2,
    RPS_REDIRECT_ZERO_STATE = 4'h3,
    RPS_REDIRECT_ONE_STATE = 4'h4,
    RPS_LOOPBACK_ZERO_STATE = 4'h5,
    RPS_LOOPBACK_ONE_STATE = 4'h6,
    RPS_TRANSMIT = 4'h7,
    RPS_WAIT = 4'h8
  } rps_state_e;

endpackage

// ---- verilog/rps_req_store.sv ----
// Holding store for one accepted client request.
// Assumes the writer is on mclk; read data come from registers.
`timescale 1ns/1ps
`default_nettype none
`include "rps_regs.svh"

module rps_req_store (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wrEn,
  input wire logic [`RPS_ADDR_W-1:0] wrDestAddr,
  input wire logic wrProtectChoice,
  input wire logic wrFairnessEligibleMark,
  input wire logic [1:0] wrRequestedRingPath,
  output logic [`RPS_ADDR_W-1:0] rdDestAddr,
  output logic rdProtectChoice,
  output logic rdFairnessEligibleMark,
  output logic [1:0] rdRequestedRingPath
);

  logic [`RPS_ADDR_W-1:0] next_rdDestAddr;
  logic next_rdProtectChoice;
  logic next_rdFairnessEligibleMark;
  logic [1:0] next_rdRequestedRingPath;

  always_comb begin
    next_rdDestAddr = rdDestAddr;
    next_rdProtectChoice = rdProtectChoice;
    next_rdFairnessEligibleMark = rdFairnessEligibleMark;
    next_rdRequestedRingPath = rdRequestedRingPath;
    if (wrEn) begin
      next_rdDestAddr = wrDestAddr;
      next_rdProtectChoice = wrProtectChoice;
      next_rdFairnessEligibleMark = wrFairnessEligibleMark;
      next_rdRequestedRingPath = wrRequestedRingPath;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdDestAddr <= `RPS_RST_ADDR;
      rdProtectChoice <= `RPS_NO_PROTECT;
      rdFairnessEligibleMark <= 1'h0;
      rdRequestedRingPath <= `RPS_REQ_PATH_ZERO;
    end else begin
      rdDestAddr <= next_rdDestAddr;
      rdProtectChoice <= next_rdProtectChoice;
      rdFairnessEligibleMark <= next_rdFairnessEligibleMark;
      rdRequestedRingPath <= next_rdRequestedRingPath;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/rps_ring_path_selector.sv ----
// Ring path selector: picks ringlet(s) and header marks for client frames.
// Assumes client, topology database and stage queues all run on mclk;
// the database answers reachability combinationally for topoQueryAddr.
//
// Functional notes
// RULE_01: Transitions tested in priority order, first wins.
// RULE_02: Requested ringlet selects the matching path state.
// RULE_03: Default or no ringlet: own alternating pick.
// RULE_04: No_protect: set path field, steer_only_mark, transmit.
// RULE_05: Protected: steer if not wrap capable, else loopback.
// RULE_06: Loopback state: own path, wrap eligible, transmit.
// RULE_07: Redirect zero: prefer ringlet zero for unicast.
// RULE_08: Redirect one: prefer ringlet one for unicast.
// RULE_09: Unreachable unicast is dropped, back to waiting.
// RULE_10: Optional single-ringlet multicast, own ringlet first.
// RULE_11: Otherwise multicast duplicated onto both ringlets.
// RULE_12: Transmit hands frames to queues, then waits.
// RULE_13: Waiting idles until a new client request.
// RULE_14: Database reports reachability per ringlet.
// RULE_15: Client supplies address, protection, fairness, ringlet.
// RULE_16: Duplicates differ only in path, offered together.
`timescale 1ns/1ps
`default_nettype none
`include "rps_regs.svh"

module rps_ring_path_selector (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [`RPS_ADDR_W-1:0] reqDestAddr,
  input wire logic reqProtectChoice,
  input wire logic reqFairnessEligibleMark,
  input wire logic [1:0] reqRequestedRingPath,
  input wire logic loopbackCapableFlag,
  input wire logic multicastSingleEn,
  output logic [`RPS_ADDR_W-1:0] topoQueryAddr,
  input wire logic reachPathZero,
  input wire logic reachPathOne,
  output logic q0Valid,
  input wire logic q0Ready,
  output logic q0HdrPathField,
  output logic q1Valid,
  input wire logic q1Ready,
  output logic q1HdrPathField,
  output logic [`RPS_ADDR_W-1:0] txDestAddr,
  output logic txFairnessEligibleMark,
  output logic txLoopbackOkMark,
  output logic dropPulse,
  output logic [`RPS_CNT_W-1:0] dropCount,
  output logic [`RPS_CNT_W-1:0] dupCount,
  output logic [3:0] stateCode
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  rps_pkg::rps_state_e state;
  rps_pkg::rps_state_e next_state;
  logic next_reqReady;
  logic next_q0Valid;
  logic next_q1Valid;
  logic next_q0HdrPathField;
  logic next_q1HdrPathField;
  logic next_txLoopbackOkMark;
  logic next_dropPulse;
  logic [`RPS_CNT_W-1:0] next_dropCount;
  logic [`RPS_CNT_W-1:0] next_dupCount;
  logic defaultPickOne;
  logic next_defaultPickOne;
  logic storeWr;
  logic [`RPS_ADDR_W-1:0] heldDestAddr;
  logic heldProtectChoice;
  logic heldFairnessEligibleMark;
  logic [1:0] heldRequestedRingPath;
  logic q0Pending;
  logic q1Pending;

  ////////////////////////////////////////////////////////////////////////////
  // Address class decode

  function automatic logic isUnicast(input logic [`RPS_ADDR_W-1:0] addr);
    isUnicast = ~addr[`RPS_GROUP_BIT];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request capture

  assign storeWr = reqValid & reqReady; // RULE_13

  rps_req_store u_req_store (
    .mclk(mclk),
    .resetn(resetn),
    .wrEn(storeWr),
    .wrDestAddr(reqDestAddr),
    .wrProtectChoice(reqProtectChoice),
    .wrFairnessEligibleMark(reqFairnessEligibleMark),
    .wrRequestedRingPath(reqRequestedRingPath),
    .rdDestAddr(heldDestAddr),
    .rdProtectChoice(heldProtectChoice),
    .rdFairnessEligibleMark(heldFairnessEligibleMark),
    .rdRequestedRingPath(heldRequestedRingPath)
  );

  // Both copies read the same held fields; only the path differs
  assign txDestAddr = heldDestAddr; // RULE_16
  assign txFairnessEligibleMark = heldFairnessEligibleMark; // RULE_16
  assign topoQueryAddr = heldDestAddr;
  assign stateCode = state;

  // Copies still waiting for their queue
  assign q0Pending = q0Valid & ~q0Ready;
  assign q1Pending = q1Valid & ~q1Ready;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_state = state;
    next_reqReady = 1'h0;
    next_q0Valid = q0Valid;
    next_q1Valid = q1Valid;
    next_q0HdrPathField = q0HdrPathField;
    next_q1HdrPathField = q1HdrPathField;
    next_txLoopbackOkMark = txLoopbackOkMark;
    next_dropPulse = 1'h0;
    next_dropCount = dropCount;
    next_dupCount = dupCount;
    next_defaultPickOne = defaultPickOne;
    unique case (state)
      rps_pkg::RPS_START: begin
        if (heldRequestedRingPath == `RPS_REQ_PATH_ZERO) begin // RULE_01
          next_state = rps_pkg::RPS_PATH_ZERO_STATE; // RULE_02
        end else if (heldRequestedRingPath == `RPS_REQ_PATH_ONE) begin
          next_state = rps_pkg::RPS_PATH_ONE_STATE; // RULE_02
        end else begin
          // Alternate between ringlets to spread default traffic
          next_state = defaultPickOne ? rps_pkg::RPS_PATH_ONE_STATE :
                                        rps_pkg::RPS_PATH_ZERO_STATE; // RULE_03
          next_defaultPickOne = ~defaultPickOne; // RULE_03
        end
      end
      rps_pkg::RPS_PATH_ZERO_STATE: begin
        if (heldProtectChoice == `RPS_NO_PROTECT) begin // RULE_01
          next_q0Valid = 1'h1; // RULE_04
          next_q0HdrPathField = `RPS_HDR_PATH_ZERO; // RULE_04
          next_txLoopbackOkMark = `RPS_STEER_ONLY_MARK; // RULE_04
          next_state = rps_pkg::RPS_TRANSMIT; // RULE_04
        end else if (!loopbackCapableFlag) begin
          next_state = rps_pkg::RPS_REDIRECT_ZERO_STATE; // RULE_05
        end else begin
          next_state = rps_pkg::RPS_LOOPBACK_ZERO_STATE; // RULE_05
        end
      end
      rps_pkg::RPS_PATH_ONE_STATE: begin
        if (heldProtectChoice == `RPS_NO_PROTECT) begin // RULE_01
          next_q1Valid = 1'h1; // RULE_04
          next_q1HdrPathField = `RPS_HDR_PATH_ONE; // RULE_04
          next_txLoopbackOkMark = `RPS_STEER_ONLY_MARK; // RULE_04
          next_state = rps_pkg::RPS_TRANSMIT; // RULE_04
        end else if (!loopbackCapableFlag) begin
          next_state = rps_pkg::RPS_REDIRECT_ONE_STATE; // RULE_05
        end else begin
          next_state = rps_pkg::RPS_LOOPBACK_ONE_STATE; // RULE_05
        end
      end
      rps_pkg::RPS_REDIRECT_ZERO_STATE: begin
        next_txLoopbackOkMark = `RPS_STEER_ONLY_MARK;
        if (isUnicast(heldDestAddr) && reachPathZero) begin // RULE_01
          next_q0Valid = 1'h1; // RULE_07
          next_q0HdrPathField = `RPS_HDR_PATH_ZERO; // RULE_07
          next_state = rps_pkg::RPS_TRANSMIT;
        end else if (isUnicast(heldDestAddr) && reachPathOne) begin
          next_q1Valid = 1'h1; // RULE_07
          next_q1HdrPathField = `RPS_HDR_PATH_ONE; // RULE_07
          next_state = rps_pkg::RPS_TRANSMIT;
        end else if (isUnicast(heldDestAddr)) begin
          next_dropPulse = 1'h1; // RULE_09
          next_dropCount = dropCount + 16'h0001; // RULE_09
          next_reqReady = 1'h1; // RULE_09
          next_state = rps_pkg::RPS_WAIT; // RULE_09
        end else if (multicastSingleEn && reachPathZero) begin
          next_q0Valid = 1'h1; // RULE_10
          next_q0HdrPathField = `RPS_HDR_PATH_ZERO; // RULE_10
          next_state = rps_pkg::RPS_TRANSMIT;
        end else if (multicastSingleEn && reachPathOne) begin
          next_q1Valid = 1'h1; // RULE_10
          next_q1HdrPathField = `RPS_HDR_PATH_ONE; // RULE_10
          next_state = rps_pkg::RPS_TRANSMIT;
        end else begin
          next_q0Valid = 1'h1; // RULE_11
          next_q1Valid = 1'h1; // RULE_11
          next_q0HdrPathField = `RPS_HDR_PATH_ZERO; // RULE_11
          next_q1HdrPathField = `RPS_HDR_PATH_ONE; // RULE_11
          next_dupCount = dupCount + 16'h0001;
          next_state = rps_pkg::RPS_TRANSMIT;
        end
      end
      rps_pkg::RPS_REDIRECT_ONE_STATE: begin
        next_txLoopbackOkMark = `RPS_STEER_ONLY_MARK;
        if (isUnicast(heldDestAddr) && reachPathOne) begin // RULE_01
          next_q1Valid = 1'h1; // RULE_08
          next_q1HdrPathField = `RPS_HDR_PATH_ONE; // RULE_08
          next_state = rps_pkg::RPS_TRANSMIT;
        end else if (isUnicast(heldDestAddr) && reachPathZero) begin
          next_q0Valid = 1'h1; // RULE_08
          next_q0HdrPathField = `RPS_HDR_PATH_ZERO; // RULE_08
          next_state = rps_pkg::RPS_TRANSMIT;
        end else if (isUnicast(heldDestAddr)) begin
          next_dropPulse = 1'h1; // RULE_09
          next_dropCount = dropCount + 16'h0001; // RULE_09
          next_reqReady = 1'h1; // RULE_09
          next_state = rps_pkg::RPS_WAIT; // RULE_09
        end else if (multicastSingleEn && reachPathOne) begin
          next_q1Valid = 1'h1; // RULE_10
          next_q1HdrPathField = `RPS_HDR_PATH_ONE; // RULE_10
          next_state = rps_pkg::RPS_TRANSMIT;
        end else if (multicastSingleEn && reachPathZero) begin
          next_q0Valid = 1'h1; // RULE_10
          next_q0HdrPathField = `RPS_HDR_PATH_ZERO; // RULE_10
          next_state = rps_pkg::RPS_TRANSMIT;
        end else begin
          next_q0Valid = 1'h1; // RULE_11
          next_q1Valid = 1'h1; // RULE_11
          next_q0HdrPathField = `RPS_HDR_PATH_ZERO; // RULE_11
          next_q1HdrPathField = `RPS_HDR_PATH_ONE; // RULE_11
          next_dupCount = dupCount + 16'h0001;
          next_state = rps_pkg::RPS_TRANSMIT;
        end
      end
      rps_pkg::RPS_LOOPBACK_ZERO_STATE: begin
        next_q0Valid = 1'h1; // RULE_06
        next_q0HdrPathField = `RPS_HDR_PATH_ZERO; // RULE_06
        next_txLoopbackOkMark = `RPS_LOOPBACK_OK_MARK; // RULE_06
        next_state = rps_pkg::RPS_TRANSMIT; // RULE_06
      end
      rps_pkg::RPS_LOOPBACK_ONE_STATE: begin
        next_q1Valid = 1'h1; // RULE_06
        next_q1HdrPathField = `RPS_HDR_PATH_ONE; // RULE_06
        next_txLoopbackOkMark = `RPS_LOOPBACK_OK_MARK; // RULE_06
        next_state = rps_pkg::RPS_TRANSMIT; // RULE_06
      end
      rps_pkg::RPS_TRANSMIT: begin
        // Hold each copy until its stage queue takes it
        next_q0Valid = q0Pending; // RULE_12
        next_q1Valid = q1Pending; // RULE_12
        if (!q0Pending && !q1Pending) begin
          next_reqReady = 1'h1; // RULE_12
          next_state = rps_pkg::RPS_WAIT; // RULE_12
        end
      end
      rps_pkg::RPS_WAIT: begin
        if (storeWr) begin // RULE_13
          next_state = rps_pkg::RPS_START; // RULE_13
        end else begin
          next_reqReady = 1'h1; // RULE_13
        end
      end
      default: begin
        next_q0Valid = 1'h0;
        next_q1Valid = 1'h0;
        next_reqReady = 1'h1;
        next_state = rps_pkg::RPS_WAIT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= rps_pkg::RPS_WAIT;
      reqReady <= 1'h1;
      q0Valid <= 1'h0;
      q1Valid <= 1'h0;
      q0HdrPathField <= `RPS_HDR_PATH_ZERO;
      q1HdrPathField <= `RPS_HDR_PATH_ONE;
      txLoopbackOkMark <= `RPS_STEER_ONLY_MARK;
      dropPulse <= 1'h0;
      dropCount <= `RPS_RST_CNT;
      dupCount <= `RPS_RST_CNT;
      defaultPickOne <= 1'h0;
    end else begin
      state <= next_state;
      reqReady <= next_reqReady;
      q0Valid <= next_q0Valid;
      q1Valid <= next_q1Valid;
      q0HdrPathField <= next_q0HdrPathField;
      q1HdrPathField <= next_q1HdrPathField;
      txLoopbackOkMark <= next_txLoopbackOkMark;
      dropPulse <= next_dropPulse;
      dropCount <= next_dropCount;
      dupCount <= next_dupCount;
      defaultPickOne <= next_defaultPickOne;
    end
  end

endmodule

`default_nettype wire

// ---- verification/rps_ring_path_selector_props.sv ----
// Port-level checker for the ring path selector.
// Assumes a bind onto rps_ring_path_selector; one mclk domain.
`timescale 1ns/1ps
`default_nettype none
`include "rps_regs.svh"

module rps_ring_path_selector_props (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic loopbackCapableFlag,
  input wire logic multicastSingleEn,
  input wire logic [`RPS_ADDR_W-1:0] topoQueryAddr,
  input wire logic reachPathZero,
  input wire logic reachPathOne,
  input wire logic q0Valid,
  input wire logic q0Ready,
  input wire logic q0HdrPathField,
  input wire logic q1Valid,
  input wire logic q1HdrPathField,
  input wire logic txLoopbackOkMark,
  input wire logic dropPulse,
  input wire logic [`RPS_CNT_W-1:0] dropCount,
  input wire logic [3:0] stateCode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic uni = !topoQueryAddr[`RPS_GROUP_BIT];
  wire logic redir = stateCode == 4'h3 || stateCode == 4'h4;
  ////////////////////////////////////////////////////////////////////////////////
  a_take_to_start:
    assert property (reqValid && reqReady |=> !reqReady && stateCode == 4'h0)
    else $error("request not taken into start");
  a_wait_idle:
    assert property (stateCode == 4'h8 && !reqValid |=> stateCode == 4'h8 && reqReady)
    else $error("left wait without request");
  a_zero_choice:
    assert property (stateCode == 4'h1 |=> (stateCode == 4'h7 && q0Valid && !q1Valid
      && !q0HdrPathField && !txLoopbackOkMark) || (stateCode == 4'h3
      && !$past(loopbackCapableFlag)) || (stateCode == 4'h5 && $past(loopbackCapableFlag)))
    else $error("wrong step from path zero");
  a_loop_mark:
    assert property (stateCode == 4'h5 || stateCode == 4'h6 |=> stateCode == 4'h7
      && txLoopbackOkMark && q0Valid != q1Valid && q1Valid == $past(stateCode == 4'h6))
    else $error("loopback frame wrong");
  a_steer_zero:
    assert property (stateCode == 4'h3 && uni && reachPathZero |=> q0Valid && !q1Valid
      && !txLoopbackOkMark)
    else $error("redirect zero did not prefer zero");
  a_steer_one:
    assert property (stateCode == 4'h4 && uni && reachPathOne |=> q1Valid && !q0Valid
      && !txLoopbackOkMark)
    else $error("redirect one did not prefer one");
  a_drop_unreach:
    assert property (redir && uni && !reachPathZero && !reachPathOne |=> stateCode == 4'h8
      && dropPulse && !q0Valid && !q1Valid)
    else $error("unreachable unicast not dropped");
  a_drop_count:
    assert property (dropPulse |-> dropCount == $past(dropCount) + 16'h1)
    else $error("drop count not advanced");
  a_single_copy:
    assert property (redir && !uni && multicastSingleEn && (reachPathZero || reachPathOne)
      |=> q0Valid != q1Valid)
    else $error("single ringlet multicast duplicated");
  a_dup_both:
    assert property (redir && !uni && !multicastSingleEn |=> q0Valid && q1Valid
      && !q0HdrPathField && q1HdrPathField)
    else $error("multicast not duplicated");
  a_xmit_exit:
    assert property (stateCode == 4'h7 && q0Valid && !q0Ready |=> q0Valid
      ##[0:12] stateCode == 4'h8)
    else $error("transmit did not hold or finish");
  c_drop: cover property (dropPulse);
  c_dup: cover property (q0Valid && q1Valid);
  c_loop: cover property (stateCode == 4'h6);
endmodule
`default_nettype wire

// ---- verification/rps_far_model.sv ----
// Far side model: topology database and both stage queues.
// Assumes the mclk domain; the bench sets the reach answers.
`timescale 1ns/1ps
`default_nettype none

module rps_far_model (
  input wire logic mclk,
  input wire logic reachSetZero,
  input wire logic reachSetOne,
  input wire logic q0Valid,
  input wire logic q1Valid,
  output logic reachPathZero,
  output logic reachPathOne,
  output logic q0Ready,
  output logic q1Ready
);
  logic [1:0] c0, c1, d0, d1;
  assign reachPathZero = reachSetZero;
  assign reachPathOne = reachSetOne;
  initial begin
    q0Ready = 1'b0;
    q1Ready = 1'b0;
  end
  // Each copy is taken after a random stall of 1 to 4 cycles (0 to 3 plus the registered ready)
  always @(posedge mclk) begin
    d0 <= q0Valid ? d0 : 2'($urandom_range(3, 0));
    d1 <= q1Valid ? d1 : 2'($urandom_range(3, 0));
    c0 <= q0Valid ? c0 + 2'h1 : 2'h0;
    c1 <= q1Valid ? c1 + 2'h1 : 2'h0;
    q0Ready <= q0Valid && c0 >= d0;
    q1Ready <= q1Valid && c1 >= d1;
  end
endmodule
`default_nettype wire

// ---- verification/rps_ring_path_selector_tb.sv ----
// Self-checking bench for the ring path selector, random requests.
// Assumes rps_far_model stands for the database and stage queues.
`timescale 1ns/1ps
`default_nettype none
`include "rps_regs.svh"
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module rps_ring_path_selector_tb;
  logic mclk = 0, resetn = 0, reqValid = 0, reqProtectChoice = 0, reqFairnessEligibleMark = 0;
  logic [`RPS_ADDR_W-1:0] reqDestAddr = '0, topoQueryAddr, txDestAddr;
  logic [1:0] reqRequestedRingPath = '0;
  logic loopbackCapableFlag = 0, multicastSingleEn = 0, reachSetZero = 0, reachSetOne = 0;
  logic reqReady, reachPathZero, reachPathOne, q0Valid, q0Ready, q0HdrPathField;
  logic q1Valid, q1Ready, q1HdrPathField, txFairnessEligibleMark, txLoopbackOkMark, dropPulse;
  logic [`RPS_CNT_W-1:0] dropCount, dupCount, expDrop = '0, expDup = '0;
  logic [3:0] stateCode;
  logic [52:0] expQ[$];
  logic altRing = 0;
  int error_cnt = 0, checked = 0, cycleCnt = 0;

  always #10 mclk = ~mclk;
  rps_ring_path_selector dut (.mclk(mclk), .resetn(resetn), .reqValid(reqValid),
    .reqReady(reqReady), .reqDestAddr(reqDestAddr), .reqProtectChoice(reqProtectChoice),
    .reqFairnessEligibleMark(reqFairnessEligibleMark), .reqRequestedRingPath(reqRequestedRingPath),
    .loopbackCapableFlag(loopbackCapableFlag), .multicastSingleEn(multicastSingleEn),
    .topoQueryAddr(topoQueryAddr), .reachPathZero(reachPathZero), .reachPathOne(reachPathOne),
    .q0Valid(q0Valid), .q0Ready(q0Ready), .q0HdrPathField(q0HdrPathField), .q1Valid(q1Valid),
    .q1Ready(q1Ready), .q1HdrPathField(q1HdrPathField), .txDestAddr(txDestAddr),
    .txFairnessEligibleMark(txFairnessEligibleMark), .txLoopbackOkMark(txLoopbackOkMark),
    .dropPulse(dropPulse), .dropCount(dropCount), .dupCount(dupCount), .stateCode(stateCode));
  rps_far_model far (.mclk(mclk), .reachSetZero(reachSetZero), .reachSetOne(reachSetOne),
    .q0Valid(q0Valid), .q1Valid(q1Valid), .reachPathZero(reachPathZero),
    .reachPathOne(reachPathOne), .q0Ready(q0Ready), .q1Ready(q1Ready));
  ////////////////////////////////////////////////////////////////////////////////
  // Result word: queue code, header path, loopback mark, fairness, address
  function automatic logic [52:0] res(input logic [1:0] q, input logic hdr);
    res = {q, hdr, txLoopbackOkMark, txFairnessEligibleMark, txDestAddr};
  endfunction
  function automatic void push(input logic r, input logic lp);
    expQ.push_back({1'b0, r, r, lp, reqFairnessEligibleMark, reqDestAddr});
  endfunction
  // Duplicate copies may be taken in either order: use oldest note of that queue
  task automatic chk(input logic [52:0] got);
    logic [52:0] e;
    int i;
    e = 'x;
    i = (expQ.size() > 1 && expQ[0][52:51] !== got[52:51]) ? 1 : 0;
    if (expQ.size() > i) begin
      e = expQ[i];
      expQ.delete(i);
    end
    `CMP(got, e)
  endtask
  always @(posedge mclk) begin
    if (resetn) begin
      if (q0Valid && q0Ready) chk(res(2'h0, q0HdrPathField));
      if (q1Valid && q1Ready) chk(res(2'h1, q1HdrPathField));
      if (dropPulse) chk({2'h2, 51'h0});
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic sendReq();
    logic ring, uni, ownOk, othOk;
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 40) begin
      @(posedge mclk) #1;
      n++;
    end
    n = $urandom_range(2, 0);
    repeat (n) @(posedge mclk) #1;
    reqDestAddr = 48'({$urandom, $urandom});
    {reqProtectChoice, reqFairnessEligibleMark, reqRequestedRingPath, loopbackCapableFlag,
      multicastSingleEn, reachSetZero, reachSetOne} = 8'($urandom);
    reqValid = 1;
    ring = reqRequestedRingPath[1] ? altRing : reqRequestedRingPath[0];
    if (reqRequestedRingPath[1]) altRing = !altRing;
    uni = !reqDestAddr[`RPS_GROUP_BIT];
    ownOk = ring ? reachSetOne : reachSetZero;
    othOk = ring ? reachSetZero : reachSetOne;
    if (!reqProtectChoice) push(ring, `RPS_STEER_ONLY_MARK);
    else if (loopbackCapableFlag) push(ring, `RPS_LOOPBACK_OK_MARK);
    else if ((uni || multicastSingleEn) && ownOk) push(ring, 1'b0);
    else if ((uni || multicastSingleEn) && othOk) push(!ring, 1'b0);
    else if (uni) begin
      expQ.push_back({2'h2, 51'h0});
      expDrop++;
    end else begin
      push(1'b0, 1'b0);
      push(1'b1, 1'b0);
      expDup++;
    end
    @(posedge mclk) #1;
    reqValid = 0;
    `CMP(reqReady, 1'b0)
    `CMP(topoQueryAddr, reqDestAddr)
  endtask
  task automatic end_of_test();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycleCnt++;
    if (cycleCnt == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(81));
    repeat (10) @(posedge mclk);
    #1 resetn = 1;
    `CMP({reqReady, stateCode, q0HdrPathField, q1HdrPathField}, 7'h61)
    `CMP({dropCount, dupCount}, {`RPS_RST_CNT, `RPS_RST_CNT})
    $display("test reset done");
    repeat (400) sendReq();
    repeat (20) @(posedge mclk);
    #1;
    `CMP(expQ.size(), 0)
    `CMP(dropCount, expDrop)
    `CMP(dupCount, expDup)
    $display("test random done");
    end_of_test();
  end
endmodule

bind rps_ring_path_selector rps_ring_path_selector_props props (.mclk(mclk), .resetn(resetn),
  .reqValid(reqValid), .reqReady(reqReady), .loopbackCapableFlag(loopbackCapableFlag),
  .multicastSingleEn(multicastSingleEn), .topoQueryAddr(topoQueryAddr),
  .reachPathZero(reachPathZero), .reachPathOne(reachPathOne), .q0Valid(q0Valid),
  .q0Ready(q0Ready), .q0HdrPathField(q0HdrPathField), .q1Valid(q1Valid),
  .q1HdrPathField(q1HdrPathField), .txLoopbackOkMark(txLoopbackOkMark),
  .dropPulse(dropPulse), .dropCount(dropCount), .stateCode(stateCode));
`default_nettype wire
